// ### src/imp_sweep_regs.svh
// Register offsets, field positions and reset values of the sweep register bank
`ifndef IMP_SWEEP_REGS_SVH
`define IMP_SWEEP_REGS_SVH
`define ADDR_CTRL_HI      8'h80
`define ADDR_CTRL_LO      8'h81
`define ADDR_START_HI     8'h82
`define ADDR_START_MID    8'h83
`define ADDR_START_LO     8'h84
`define ADDR_STEP_HI      8'h85
`define ADDR_STEP_MID     8'h86
`define ADDR_STEP_LO      8'h87
`define ADDR_COUNT_HI     8'h88
`define ADDR_COUNT_LO     8'h89
`define ADDR_SETTLE_HI    8'h8a
`define ADDR_SETTLE_LO    8'h8b
`define ADDR_LEAK_A       8'h8c
`define ADDR_LEAK_B       8'h8d
`define ADDR_LEAK_C       8'h8e
`define ADDR_STATUS       8'h8f
`define ADDR_INDEX_HI     8'h90
`define ADDR_INDEX_LO     8'h91
`define ADDR_TEMP_HI      8'h92
`define ADDR_TEMP_LO      8'h93
`define CTRL_RESET        16'ha000
`define CMD_MSB           15
`define CMD_LSB           11
`define COUNT_BITS        9
`define SETTLE_MULT_MSB   10
`define SETTLE_MULT_LSB   9
`define LEAK_BITS         4
`define TEMP_BITS         14
`define TEMP_SIGN_BIT     13
`endif

// ### src/imp_sweep_pkg.sv
// Types of the sweep register bank
`default_nettype none
package imp_sweep_pkg;
    typedef enum logic [4:0] {
        CMD_NOP       = 5'h00,
        CMD_INIT      = 5'h01,
        CMD_SWEEP     = 5'h02,
        CMD_INCREMENT = 5'h03,
        CMD_REPEAT    = 5'h04
    } sweep_cmd_e;
    typedef enum logic [1:0] {
        MULT_X1       = 2'h0,
        MULT_RSVD_A   = 2'h1,
        MULT_RSVD_B   = 2'h2,
        MULT_X4       = 2'h3
    } settle_mult_e;
endpackage
`default_nettype wire

// ### src/impedance_sweep_register_map.sv
// Byte-wide sweep configuration and result register bank
//
// Behaviour
// - Byte registers, most significant byte lowest address
// - 24-bit start and step words, read/write
// - Step count uses low nine bits only
// - Settling count, two-bit multiplier, x4 code
// - Three four-bit leakage limits at 8c-8e
// - Index counter clears on init command, increments
// - Temperature reported in 1/32 degree steps
// - Negative temperature is 14-bit two's complement
// - Control word and status byte read/write
// - Control bits 15-11 decode sweep commands
`timescale 1ns/1ps
`default_nettype none
`include "imp_sweep_regs.svh"

module impedance_sweep_register_map #(
    parameter int COUNT_W = `COUNT_BITS
) (
    input  wire logic        mclk_i,
    input  wire logic        rst_i,
    input  wire logic        wr_en_i,
    input  wire logic        rd_en_i,
    input  wire logic [7:0]  addr_i,
    input  wire logic [7:0]  wdata_i,
    input  wire logic [13:0] temp_code_i,
    input  wire logic        temp_valid_i,
    output logic      [7:0]  rdata_o,
    output logic             rvalid_o,
    output logic      [23:0] start_freq_o,
    output logic      [23:0] freq_step_o,
    output logic      [8:0]  step_count_o,
    output logic      [10:0] settle_cycles_o,
    output logic      [3:0]  leak_a_o,
    output logic      [3:0]  leak_b_o,
    output logic      [3:0]  leak_c_o,
    output logic      [8:0]  freq_index_o,
    output logic             excite_o,
    output logic             sweep_start_o,
    output logic             freq_step_pulse_o,
    output logic             freq_repeat_o,
    output logic      [15:0] control_o
);

////////////////////////////////////////////////////////////////////////////////
// Storage

logic [15:0]  ctrl_ff;
logic [23:0]  start_ff;
logic [23:0]  step_ff;
logic [8:0]   count_ff;
logic [10:0]  settle_ff;
logic [3:0]   leak_a_ff;
logic [3:0]   leak_b_ff;
logic [3:0]   leak_c_ff;
logic [7:0]   status_ff;
logic [8:0]   index_ff;
logic [13:0]  temp_ff;
logic [7:0]   rdata_ff;
logic         rvalid_ff;
logic         excite_ff;
logic         sweep_ff;
logic         stepp_ff;
logic         repeat_ff;
logic         cmd_pend_ff;
logic [7:0]   nxt_rdata;
imp_sweep_pkg::sweep_cmd_e cmd;

assign cmd = imp_sweep_pkg::sweep_cmd_e'(ctrl_ff[`CMD_MSB:`CMD_LSB]);

////////////////////////////////////////////////////////////////////////////////
// Writes; high byte at lowest address

always_ff @(posedge mclk_i) begin
    if (rst_i) begin
        ctrl_ff   <= `CTRL_RESET;
        start_ff  <= 24'h000000;
        step_ff   <= 24'h000000;
        count_ff  <= 9'h000;
        settle_ff <= 11'h000;
        leak_a_ff <= 4'h0;
        leak_b_ff <= 4'h0;
        leak_c_ff <= 4'h0;
        status_ff <= 8'h00;
    end else if (wr_en_i) begin
        case (addr_i)
            `ADDR_CTRL_HI:   ctrl_ff[15:8]    <= wdata_i;
            `ADDR_CTRL_LO:   ctrl_ff[7:0]     <= wdata_i;
            `ADDR_START_HI:  start_ff[23:16]  <= wdata_i;
            `ADDR_START_MID: start_ff[15:8]   <= wdata_i;
            `ADDR_START_LO:  start_ff[7:0]    <= wdata_i;
            `ADDR_STEP_HI:   step_ff[23:16]   <= wdata_i;
            `ADDR_STEP_MID:  step_ff[15:8]    <= wdata_i;
            `ADDR_STEP_LO:   step_ff[7:0]     <= wdata_i;
            `ADDR_COUNT_HI:  count_ff[8]      <= wdata_i[0];
            `ADDR_COUNT_LO:  count_ff[7:0]    <= wdata_i;
            `ADDR_SETTLE_HI: settle_ff[10:8]  <= wdata_i[2:0];
            `ADDR_SETTLE_LO: settle_ff[7:0]   <= wdata_i;
            `ADDR_LEAK_A:    leak_a_ff        <= wdata_i[3:0];
            `ADDR_LEAK_B:    leak_b_ff        <= wdata_i[3:0];
            `ADDR_LEAK_C:    leak_c_ff        <= wdata_i[3:0];
            `ADDR_STATUS:    status_ff        <= wdata_i;
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// Command decode: acted on once after each write to the command byte

always_ff @(posedge mclk_i) begin
    if (rst_i) begin
        cmd_pend_ff <= 1'b0;
    end else begin
        cmd_pend_ff <= wr_en_i && (addr_i == `ADDR_CTRL_HI);
    end
end

always_ff @(posedge mclk_i) begin
    if (rst_i) begin
        excite_ff <= 1'b0;
        sweep_ff  <= 1'b0;
        stepp_ff  <= 1'b0;
        repeat_ff <= 1'b0;
    end else begin
        sweep_ff  <= cmd_pend_ff && (cmd == imp_sweep_pkg::CMD_SWEEP);
        stepp_ff  <= cmd_pend_ff && (cmd == imp_sweep_pkg::CMD_INCREMENT);
        repeat_ff <= cmd_pend_ff && (cmd == imp_sweep_pkg::CMD_REPEAT);
        if (cmd_pend_ff) begin
            case (cmd)
                imp_sweep_pkg::CMD_INIT:      excite_ff <= 1'b1;
                imp_sweep_pkg::CMD_SWEEP,
                imp_sweep_pkg::CMD_INCREMENT,
                imp_sweep_pkg::CMD_REPEAT:    excite_ff <= excite_ff;
                default:                      excite_ff <= 1'b0;
            endcase
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Frequency index counter

always_ff @(posedge mclk_i) begin
    if (rst_i) begin
        index_ff <= 9'h000;
    end else if (cmd_pend_ff && (cmd == imp_sweep_pkg::CMD_INIT)) begin
        index_ff <= 9'h000;
    end else if (cmd_pend_ff && (cmd == imp_sweep_pkg::CMD_INCREMENT)) begin
        index_ff <= index_ff + 9'h001;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Temperature capture, code kept as 14-bit two's complement

always_ff @(posedge mclk_i) begin
    if (rst_i) begin
        temp_ff <= 14'h0000;
    end else if (temp_valid_i) begin
        temp_ff <= temp_code_i;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Read path; don't-care bits read zero

always_comb begin
    case (addr_i)
        `ADDR_CTRL_HI:   nxt_rdata = ctrl_ff[15:8];
        `ADDR_CTRL_LO:   nxt_rdata = ctrl_ff[7:0];
        `ADDR_START_HI:  nxt_rdata = start_ff[23:16];
        `ADDR_START_MID: nxt_rdata = start_ff[15:8];
        `ADDR_START_LO:  nxt_rdata = start_ff[7:0];
        `ADDR_STEP_HI:   nxt_rdata = step_ff[23:16];
        `ADDR_STEP_MID:  nxt_rdata = step_ff[15:8];
        `ADDR_STEP_LO:   nxt_rdata = step_ff[7:0];
        `ADDR_COUNT_HI:  nxt_rdata = {7'h00, count_ff[8]};
        `ADDR_COUNT_LO:  nxt_rdata = count_ff[7:0];
        `ADDR_SETTLE_HI: nxt_rdata = {5'h00, settle_ff[10:8]};
        `ADDR_SETTLE_LO: nxt_rdata = settle_ff[7:0];
        `ADDR_LEAK_A:    nxt_rdata = {4'h0, leak_a_ff};
        `ADDR_LEAK_B:    nxt_rdata = {4'h0, leak_b_ff};
        `ADDR_LEAK_C:    nxt_rdata = {4'h0, leak_c_ff};
        `ADDR_STATUS:    nxt_rdata = status_ff;
        `ADDR_INDEX_HI:  nxt_rdata = {7'h00, index_ff[8]};
        `ADDR_INDEX_LO:  nxt_rdata = index_ff[7:0];
        `ADDR_TEMP_HI:   nxt_rdata = {2'h0, temp_ff[13:8]};
        `ADDR_TEMP_LO:   nxt_rdata = temp_ff[7:0];
        default:         nxt_rdata = 8'h00;
    endcase
end

always_ff @(posedge mclk_i) begin
    if (rst_i) begin
        rdata_ff  <= 8'h00;
        rvalid_ff <= 1'b0;
    end else begin
        rvalid_ff <= rd_en_i;
        if (rd_en_i) begin
            rdata_ff <= nxt_rdata;
        end
    end
end

////////////////////////////////////////////////////////////////////////////////
// Outputs

assign rdata_o           = rdata_ff;
assign rvalid_o          = rvalid_ff;
assign start_freq_o      = start_ff;
assign freq_step_o       = step_ff;
assign step_count_o      = count_ff;
assign settle_cycles_o   = settle_ff;
assign leak_a_o          = leak_a_ff;
assign leak_b_o          = leak_b_ff;
assign leak_c_o          = leak_c_ff;
assign freq_index_o      = index_ff;
assign excite_o          = excite_ff;
assign sweep_start_o     = sweep_ff;
assign freq_step_pulse_o = stepp_ff;
assign freq_repeat_o     = repeat_ff;
assign control_o         = ctrl_ff;

////////////////////////////////////////////////////////////////////////////////
// Assertions

sequence s_cmd_write(logic [4:0] code);
    wr_en_i && (addr_i == `ADDR_CTRL_HI) && (wdata_i[7:3] == code);
endsequence

a_sweep_pulse_timing: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_cmd_write(5'h02) ##1 !wr_en_i |=> sweep_start_o ##1 !sweep_start_o)
    else $error("sweep start pulse missing");
a_init_excites: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_cmd_write(5'h01) |=> ##1 excite_o && (freq_index_o == 9'h000))
    else $error("init did not excite or clear index");
a_index_increment: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_cmd_write(5'h03) |=> ##1 (freq_index_o == $past(freq_index_o) + 9'h001))
    else $error("index did not advance");
a_index_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
    !cmd_pend_ff |=> $stable(freq_index_o))
    else $error("index changed without command");
a_start_byte_order: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_en_i && addr_i == `ADDR_START_HI |=> start_freq_o[23:16] == $past(wdata_i))
    else $error("start high byte misplaced");
a_count_mask: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_en_i && addr_i == `ADDR_COUNT_HI |=> rdata_o[7:1] == 7'h00)
    else $error("count don't-care bits not zero");
a_settle_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_en_i && addr_i == `ADDR_SETTLE_HI |=> rdata_o == {5'h00, settle_cycles_o[10:8]})
    else $error("settle high byte wrong");
a_leak_mask: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_en_i && addr_i == `ADDR_LEAK_B |=> leak_b_o == $past(wdata_i[3:0]))
    else $error("leak limit b not stored");
a_temp_read: assert property (@(posedge mclk_i) disable iff (rst_i)
    rd_en_i && addr_i == `ADDR_TEMP_HI |=> rdata_o[7:6] == 2'h0)
    else $error("temperature top bits not zero");
a_ro_ignored: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_en_i && addr_i == `ADDR_TEMP_LO && !temp_valid_i |=> $stable(temp_ff))
    else $error("read-only write took effect");
a_ctrl_write: assert property (@(posedge mclk_i) disable iff (rst_i)
    wr_en_i && addr_i == `ADDR_CTRL_LO |=> control_o[7:0] == $past(wdata_i))
    else $error("control low byte not stored");

endmodule // impedance_sweep_register_map
`default_nettype wire

// ### tb/sweep_host.sv
// Host bus master model that reaches the sweep register bank
`timescale 1ns/1ps
`default_nettype none
module sweep_host (
    input  wire logic       mclk_i,
    input  wire logic [7:0] rdata_i,
    input  wire logic       rvalid_i,
    output logic            wr_en_o,
    output logic            rd_en_o,
    output logic      [7:0] addr_o,
    output logic      [7:0] wdata_o
);
    initial begin
        wr_en_o = 1'b0;
        rd_en_o = 1'b0;
        addr_o = 8'h00;
        wdata_o = 8'h00;
    end
    ////////////////////////////////////////////////////////////////////////////
    // One byte write, lines inverted once released
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        wr_en_o = 1'b1;
        addr_o = a;
        wdata_o = d;
        @(negedge mclk_i);
        wr_en_o = 1'b0;
        addr_o = ~a;
        wdata_o = ~d;
    endtask
    // One byte read, data taken while the valid pulse stands
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk_i);
        rd_en_o = 1'b1;
        addr_o = a;
        @(negedge mclk_i);
        rd_en_o = 1'b0;
        addr_o = ~a;
        d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
    endtask
endmodule // sweep_host
`default_nettype wire

// ### tb/test_impedance_sweep_register_map.sv
// Self-checking bench of the sweep register bank
`timescale 1ns/1ps
`default_nettype none
module test_impedance_sweep_register_map;
    logic        mclk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        wr_en, rd_en, temp_valid, rvalid, excite, sweep_go, step_go, rep_go;
    logic [7:0]  addr, wdata, rdata, rb;
    logic [13:0] temp_code;
    logic [23:0] start_freq, freq_step;
    logic [8:0]  step_count, freq_index;
    logic [10:0] settle;
    logic [3:0]  leak_a, leak_b, leak_c;
    logic [15:0] control;
    int          errors = 0;
    int          compares = 0;
    int          cycles = 0;
    always #12.5 mclk_i = ~mclk_i;
    impedance_sweep_register_map uut (
        .mclk_i(mclk_i), .rst_i(rst_i), .wr_en_i(wr_en), .rd_en_i(rd_en),
        .addr_i(addr), .wdata_i(wdata), .temp_code_i(temp_code),
        .temp_valid_i(temp_valid), .rdata_o(rdata), .rvalid_o(rvalid),
        .start_freq_o(start_freq), .freq_step_o(freq_step), .step_count_o(step_count),
        .settle_cycles_o(settle), .leak_a_o(leak_a), .leak_b_o(leak_b),
        .leak_c_o(leak_c), .freq_index_o(freq_index), .excite_o(excite),
        .sweep_start_o(sweep_go), .freq_step_pulse_o(step_go),
        .freq_repeat_o(rep_go), .control_o(control)
    );
    sweep_host host (
        .mclk_i(mclk_i), .rdata_i(rdata), .rvalid_i(rvalid), .wr_en_o(wr_en),
        .rd_en_o(rd_en), .addr_o(addr), .wdata_o(wdata)
    );
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [23:0] e, input logic [23:0] g);
        compares++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rb);
        chk($sformatf("byte %h", a), {16'h0000, e}, {16'h0000, rb});
    endtask
    task automatic finish_test();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 4000) begin
            errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(8'h80, 8'ha0);
        rd_chk(8'h81, 8'h00);
        chk("control", 24'h00a000, {8'h00, control});
        rd_chk(8'h8f, 8'h00);
    endtask
    task automatic t_words();
        logic [47:0] p;
        p = 48'h123456abcdef;
        for (int i = 0; i < 6; i++) host.wr(8'h82 + 8'(i), p[47 - 8 * i -: 8]);
        chk("start", 24'h123456, start_freq);
        chk("step", 24'habcdef, freq_step);
        for (int i = 0; i < 6; i++) rd_chk(8'h82 + 8'(i), p[47 - 8 * i -: 8]);
    endtask
    task automatic t_counts();
        host.wr(8'h88, 8'hff);
        host.wr(8'h89, 8'hff);
        host.wr(8'h8a, 8'hff);
        host.wr(8'h8b, 8'h34);
        chk("count", 24'h0001ff, {15'h0000, step_count});
        chk("settle", 24'h000734, {13'h0000, settle});
        rd_chk(8'h88, 8'h01);
        rd_chk(8'h8a, 8'h07);
        host.wr(8'h8a, 8'h00);
        chk("settle x1", 24'h000034, {13'h0000, settle});
    endtask
    task automatic t_bytes();
        for (int i = 0; i < 3; i++) host.wr(8'h8c + 8'(i), 8'hf5 + 8'(i));
        chk("leaks", 24'h000567, {12'h000, leak_a, leak_b, leak_c});
        for (int i = 0; i < 3; i++) rd_chk(8'h8c + 8'(i), 8'h05 + 8'(i));
        host.wr(8'h8f, 8'ha5);
        rd_chk(8'h8f, 8'ha5);
        host.wr(8'h70, 8'h33);
        rd_chk(8'h70, 8'h00);
    endtask
    task automatic cmd(input logic [7:0] b);
        host.wr(8'h80, b);
        repeat (1) @(negedge mclk_i);
    endtask
    task automatic t_cmds();
        cmd(8'h08);
        chk("init", 24'h000200, {14'h0000, excite, freq_index});
        cmd(8'h10);
        chk("sweep", 24'h000003, {22'h000000, sweep_go, excite});
        for (int i = 1; i < 4; i++) begin
            cmd(8'h18);
            chk("incr", {14'h0000, 1'b1, 9'(i)}, {14'h0000, step_go, freq_index});
        end
        host.wr(8'h91, 8'h00);
        rd_chk(8'h91, 8'h03);
        rd_chk(8'h90, 8'h00);
        cmd(8'h20);
        chk("repeat", 24'h000203, {14'h0000, rep_go, freq_index});
        cmd(8'h50);
        chk("other", 24'h000000, {23'h000000, excite});
        rd_chk(8'h80, 8'h50);
    endtask
    task automatic t_temp(input int deg);
        logic [13:0] c;
        c = 14'(deg * 32);
        @(negedge mclk_i);
        temp_code = c;
        temp_valid = 1'b1;
        @(negedge mclk_i);
        temp_valid = 1'b0;
        temp_code = ~c;
        host.wr(8'h93, ~c[7:0]);
        rd_chk(8'h92, {2'b00, c[13:8]});
        rd_chk(8'h93, c[7:0]);
    endtask
    initial begin
        temp_code = 14'h0000;
        temp_valid = 1'b0;
        repeat (20) @(negedge mclk_i);
        rst_i = 1'b0;
        t_reset();
        t_words();
        t_counts();
        t_bytes();
        t_cmds();
        t_temp(-40);
        t_temp(25);
        finish_test();
    end
endmodule // test_impedance_sweep_register_map
`default_nettype wire
